// ===== design/lsu_port_regs.vh
`ifndef LSU_PORT_REGS_VH
`define LSU_PORT_REGS_VH

// =============================================
// Operation codes
`define OP_LD32  3'h0
`define OP_LD16U 3'h1
`define OP_LD16S 3'h2
`define OP_LD8U  3'h3
`define OP_LD8S  3'h4
`define OP_ST32  3'h5
`define OP_ST16  3'h6
`define OP_ST8   3'h7

// =============================================
// Mask values and timing
`define MASK_NONE 4'h0
`define MASK_ALL  4'hF
`define MASK_LO16 4'h3
`define MASK_HI16 4'hC
`define MASK_B0   4'h1
`define LOAD_LATENCY 2

`endif

// ===== design/lane_align.v
`timescale 1ns/1ps
// =============================================
// Lane placement helper, purely combinational
module lane_align (
  // Operation inputs
  input  wire [2:0]  op_code,
  input  wire [1:0]  addr_low,
  input  wire [31:0] store_value,
  // Lane outputs
  output reg  [3:0]  lane_mask,
  output reg  [31:0] lane_data
);
`include "lsu_port_regs.vh"

  // Mask shifted by the low address bits, data replicated across the lanes, zero cycles deep
  always @* begin
    case (op_code)
      `OP_LD16U, `OP_LD16S, `OP_ST16: begin
        lane_mask = addr_low[1] ? `MASK_HI16 : `MASK_LO16;
        lane_data = {2{store_value[15:0]}};
      end
      `OP_LD8U, `OP_LD8S, `OP_ST8: begin
        lane_mask = `MASK_B0 << addr_low;
        lane_data = {4{store_value[7:0]}};
      end
      default: begin
        lane_mask = `MASK_ALL;
        lane_data = store_value;
      end
    endcase
  end
endmodule

// ===== design/lsu_memory_access_port.v
`timescale 1ns/1ps
// =============================================
// Load-store memory port of the core
module lsu_memory_access_port (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Core side
  input  wire        trigger_in,
  input  wire [2:0]  op_code,
  input  wire [31:0] op_addr,
  input  wire [31:0] op_store_data,
  input  wire        core_stall_in,
  output wire        trigger_pulse,
  output wire        stall_request,
  output reg  [31:0] load_result,
  // Request channel
  output reg         access_valid,
  input  wire        access_accept,
  output reg  [31:0] access_byte_addr,
  output reg         write_not_read,
  output reg  [3:0]  byte_lane_mask,
  output reg  [31:0] write_payload,
  // Return channel
  input  wire        return_valid,
  output reg         return_accept,
  input  wire [31:0] return_payload
);
`include "lsu_port_regs.vh"

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_REQ  = 3'b010;
  localparam [2:0] ST_RET  = 3'b100;

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [2:0]  pend_op_reg;
  wire [3:0]  lane_mask;
  wire [31:0] lane_data;
  wire        req_fire;
  wire        ret_fire;
  wire        is_store;

  // =============================================
  // Operation decoding
  // Stores finish at the request transfer and never open the return channel
  function is_store_op;
    input [2:0] op;
    begin
      case (op)
        `OP_ST32,
        `OP_ST16,
        `OP_ST8: begin
          is_store_op = 1'b1;
        end
        default: begin
          is_store_op = 1'b0;
        end
      endcase
    end
  endfunction

  // =============================================
  // Normal operation logic
  // Trigger only while the core runs, so a locked cycle never retriggers
  assign trigger_pulse = trigger_in & ~core_stall_in;
  // Direction is decided from the code seen in the trigger cycle
  assign is_store      = is_store_op(op_code);
  // Both handshakes are plain AND terms; nothing is remembered between them
  assign req_fire      = access_valid & access_accept;
  assign ret_fire      = return_valid & return_accept;

  // Lock purely from own registers and memory inputs, never from core_stall_in
  assign stall_request = (access_valid & ~access_accept) |
                         (return_accept & ~return_valid);

  lane_align u_lane (
    .op_code     (op_code),
    .addr_low    (op_addr[1:0]),
    .store_value (op_store_data),
    .lane_mask   (lane_mask),
    .lane_data   (lane_data)
  );

  // Right-justified return data extended by load kind
  // The memory has already moved the addressed bytes down to bit 0,
  // so only the width and the sign treatment are left to do here
  function [31:0] extend_load;
    input [2:0]  op;
    input [31:0] d;
    begin
      case (op)
        `OP_LD16U: extend_load = {16'h0000, d[15:0]};
        `OP_LD16S: extend_load = {{16{d[15]}}, d[15:0]};
        `OP_LD8U:  extend_load = {24'h000000, d[7:0]};
        `OP_LD8S:  extend_load = {{24{d[7]}}, d[7:0]};
        default:   extend_load = d;
      endcase
    end
  endfunction

  // =============================================
  // Sequence control
  // Idle waits for a trigger, request waits for the memory to take the
  // access, and return waits for read data; only one access is ever open
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (trigger_pulse) begin
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        if (req_fire) begin
          state_next = write_not_read ? ST_IDLE : ST_RET;
        end
      end
      ST_RET: begin
        if (ret_fire) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State register; reset parks the sequencer in idle
  always @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // =============================================
  // Request channel
  // Valid rises the cycle after the trigger and falls after the transfer.
  // A trigger while busy is ignored; the core is locked then, except in a cycle where a transfer completes.
  always @(posedge clk) begin
    if (reset) begin
      access_valid <= 1'b0;
    end else if (state_reg == ST_IDLE && trigger_pulse) begin
      access_valid <= 1'b1;
    end else if (req_fire) begin
      access_valid <= 1'b0;
    end
  end

  // Request fields are loaded once per operation and then stand still,
  // so the memory may take the access in any later cycle
  always @(posedge clk) begin
    if (reset) begin
      access_byte_addr <= 32'h00000000;
      write_not_read   <= 1'b0;
      byte_lane_mask   <= `MASK_NONE;
      write_payload    <= 32'h00000000;
      pend_op_reg      <= `OP_LD32;
    end else if (state_reg == ST_IDLE && trigger_pulse) begin
      access_byte_addr <= op_addr;
      write_not_read   <= is_store;
      byte_lane_mask   <= lane_mask;
      write_payload    <= lane_data;
      pend_op_reg      <= op_code;
    end
  end

  // =============================================
  // Return channel
  // Accept opens after a read transfer and closes once data is taken.
  // Keeping it low for stores means a stray return never reaches the result.
  always @(posedge clk) begin
    if (reset) begin
      return_accept <= 1'b0;
    end else if (ret_fire) begin
      return_accept <= 1'b0;
    end else if (req_fire) begin
      return_accept <= ~write_not_read;
    end
  end

  // =============================================
  // Post-operation logic
  // Result captured at the final cycle of the load; with the request
  // cycle in front, a load can never finish in fewer than two cycles.
  // The result register stands until the next load completes.
  always @(posedge clk) begin
    if (reset) begin
      load_result <= 32'h00000000;
    end else if (ret_fire) begin
      load_result <= extend_load(pend_op_reg, return_payload);
    end
  end

  // =============================================
  // Limitations
  // Only one access is outstanding; a memory that could pipeline
  // several requests gains nothing here, traded for a simple lock.
  // The upper address bits pass straight through, so the memory side
  // decides what an address outside its range means.
  // Store data is replicated across all lanes; the mask alone says
  // which lanes carry the valid bytes.
endmodule

// ===== bench/lsu_chk_sva.sv
`timescale 1ns/1ps
// ====================
// Port checker
module lsu_chk (
  input wire logic       clk, reset, trigger_in, core_stall_in, trigger_pulse, stall_request,
  input wire logic       access_valid, access_accept, write_not_read, return_valid, return_accept,
  input wire logic [2:0] op_code,
  input wire logic [3:0] byte_lane_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Trigger taken only when idle; busy triggers are dropped
  wire go = trigger_pulse && !access_valid && !return_accept;
  property p_lock; access_valid && !access_accept |-> stall_request; endproperty
  a_lock: assert property (p_lock) else $error("no lock");
  property p_hold; access_valid && !access_accept |=> access_valid && $stable(byte_lane_mask);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_wnr; go |=> access_valid && write_not_read == ($past(op_code) > 3'h4); endproperty
  a_wnr: assert property (p_wnr) else $error("direction");
  property p_mask;
    access_valid |-> byte_lane_mask inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  endproperty
  a_mask: assert property (p_mask) else $error("mask");
  property p_rdy; return_accept && !return_valid |-> stall_request; endproperty
  a_rdy: assert property (p_rdy) else $error("no read lock");
  property p_ret; access_valid && access_accept && !write_not_read |=> return_accept; endproperty
  a_ret: assert property (p_ret) else $error("no return accept");
  property p_trig; trigger_pulse |-> trigger_in && !core_stall_in; endproperty
  a_trig: assert property (p_trig) else $error("pulse");
  property p_rst; $fell(reset) |-> !access_valid && !return_accept; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  cover property (go);
  cover property (access_valid && !access_accept);
  cover property (return_valid && return_accept);
endmodule
bind lsu_memory_access_port lsu_chk chk (.*);

// ===== bench/mem_model.sv
`timescale 1ns/1ps
// ====================
// One-word memory; upper address bits ignored to keep it small
module mem_model (
  input wire logic        clk, slow, access_valid, write_not_read, return_accept,
  input wire logic [3:0]  byte_lane_mask,
  input wire logic [31:0] write_payload,
  output logic            access_accept, return_valid,
  output logic [31:0]     return_payload
);
  logic [31:0] mem_reg, rd_reg;
  logic        pend_reg;
  initial {access_accept, return_valid, pend_reg, mem_reg, rd_reg} = '0;
  // Accept toggles when slow and never looks at valid
  always @(posedge clk) begin
    access_accept <= !slow || !access_accept;
    if (access_valid && access_accept) begin
      for (int i = 0; i < 4; i++)
        if (write_not_read && byte_lane_mask[i]) mem_reg[8*i+:8] <= write_payload[8*i+:8];
      rd_reg <= (mem_reg >> (byte_lane_mask[0] ? 0 : byte_lane_mask[1] ? 8 :
        byte_lane_mask[2] ? 16 : 24)) & ((&byte_lane_mask) ? 32'hFFFFFFFF :
        (byte_lane_mask == 4'h3 || byte_lane_mask == 4'hC) ? 32'h0000FFFF : 32'h000000FF);
      pend_reg <= !write_not_read;
    end
    if (return_valid && return_accept) {return_valid, pend_reg} <= 2'h0;
    else if (pend_reg && (!slow || access_accept)) return_valid <= 1'b1;
  end
  // Junk on the data lines while not valid
  assign return_payload = return_valid ? rd_reg : ~rd_reg;
endmodule

// ===== bench/lsu_memory_access_port_tb.sv
`timescale 1ns/1ps
module lsu_memory_access_port_tb;
  logic        clk = 0, reset = 1, trigger_in = 0, core_stall_in = 0, slow = 0;
  logic [2:0]  op_code = 3'h0;
  logic [31:0] op_addr = 32'h0, op_store_data = 32'h0;
  wire         trigger_pulse, stall_request, access_valid, access_accept;
  wire         write_not_read, return_valid, return_accept;
  wire [3:0]   byte_lane_mask;
  wire [31:0]  load_result, access_byte_addr, write_payload, return_payload;
  int          mismatches = 0, compares = 0;
  always #4 clk = ~clk;
  lsu_memory_access_port dut (.*);
  mem_model mem (.*);
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // One operation; a load result is compared once the return lands
  task automatic run(logic [2:0] c, logic [31:0] a, logic [31:0] d, logic [31:0] e);
    int n = 0;
    {op_code, op_addr, op_store_data, trigger_in} = {c, a, d, 1'b1};
    do begin
      @(posedge clk);
      #1 trigger_in = 0;
      if (n == 0) chk("access_byte_addr", a, access_byte_addr);
      if (n == 0) chk("write_not_read", {31'h0, c > 3'h4}, {31'h0, write_not_read});
      if (access_valid) chk("stall", {31'h0, !access_accept}, {31'h0, stall_request});
      n++;
    end while (n < 50 && (access_valid || return_accept));
    if (n == 50) mismatches++;
    if (c < 3'h5) chk("load_result", e, load_result);
  endtask
  task automatic s_word;
    run(3'h5, 32'h0, 32'h8899AABB, 32'h0);
    run(3'h0, 32'h0, 32'h0, 32'h8899AABB);
  endtask
  task automatic s_lanes;
    run(3'h7, 32'h1, 32'h55, 32'h0);
    run(3'h3, 32'h1, 32'h0, 32'h55);
    run(3'h2, 32'h2, 32'h0, 32'hFFFF8899);
    run(3'h4, 32'h0, 32'h0, 32'hFFFFFFBB);
    run(3'h1, 32'h0, 32'h0, 32'h000055BB);
  endtask
  task automatic s_slow;
    slow = 1;
    run(3'h6, 32'h2, 32'h1234, 32'h0);
    run(3'h1, 32'h2, 32'h0, 32'h1234);
    slow = 0;
  endtask
  task automatic s_stall;
    {core_stall_in, trigger_in, op_code} = {2'h3, 3'h5};
    @(posedge clk);
    #1 chk("access_valid", 32'h0, {31'h0, access_valid});
    chk("trigger_pulse", 32'h0, {31'h0, trigger_pulse});
    {core_stall_in, trigger_in} = 2'h0;
  endtask
  task automatic summarize;
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 reset = 0;
    s_word;
    s_lanes;
    s_slow;
    s_stall;
    summarize;
  end
  initial begin
    #20000;
    mismatches++;
    summarize;
  end
endmodule
